// ### sps_pkg.sv
// Constants, timing counts and shared types for the sector program host.
// Assumes a single 200 MHz clock and a 64K x 16 asynchronous flash outside.
package sps_pkg;

  // Clock rate
  localparam int CLK_MHZ        = 200;

  // Pin timing in ns as printed
  localparam int T_WP_NS        = 200;   // Write pulse width low
  localparam int T_WPH_NS       = 200;   // Write pulse width high
  localparam int T_ACC_NS       = 150;   // Address to output delay
  localparam int T_OEHP_NS      = 150;   // Output enable high pulse

  // Least times, rounded up to cycles
  localparam int WP_CYC         = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WPH_CYC        = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC        = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int OEHP_CYC       = (T_OEHP_NS * CLK_MHZ + 999) / 1000;

  // Long times, in their own units
  localparam int T_WLC_US       = 150;   // Word load timeout
  localparam int T_WC_MS        = 20;    // Sector program cycle time

  // Engine counter width
  localparam int CNT_W          = 8;

  // Sector geometry
  localparam int ADDR_W         = 16;
  localparam int DATA_W         = 16;
  localparam int IDX_W          = 7;
  localparam int SECTOR_WORDS   = 128;
  localparam logic [IDX_W-1:0] LAST_IDX = 7'h7f;
  localparam int SECT_LSB       = 7;

  // Status bit positions
  localparam int TOGGLE_LOW_BIT = 6;     // toggle_flag_low
  localparam int TOGGLE_HIGH_BIT = 14;   // toggle_flag_high

  // Command preamble, addresses fifteen bits, data low byte
  localparam int PRE_STEPS      = 3;
  localparam logic [1:0] LAST_STEP = 2'h2;
  localparam logic [ADDR_W-1:0] UNL_ADDR_A = 16'h5555;
  localparam logic [ADDR_W-1:0] UNL_ADDR_B = 16'h2aaa;
  localparam logic [DATA_W-1:0] UNL_DATA_A = 16'h00aa;
  localparam logic [DATA_W-1:0] UNL_DATA_B = 16'h0055;
  localparam logic [DATA_W-1:0] CODE_PGM   = 16'h00a0;
  localparam logic [DATA_W-1:0] CODE_ID_IN = 16'h0090;
  localparam logic [DATA_W-1:0] CODE_ID_OUT = 16'h00f0;

  // User commands
  typedef enum logic [1:0] {
    OP_READ,
    OP_PROGRAM,
    OP_ID_ENTER,
    OP_ID_EXIT
  } sps_op_e;

endpackage

// ### sps_bus_if.sv
// Handshake between the sequencer and the pin cycle engine.
// Assumes both sides share one clock; start and done are one-cycle pulses.
interface sps_bus_if;
  import sps_pkg::*;

  logic              start;  // Launch one pin cycle
  logic              wr;     // High for write cycle
  logic [ADDR_W-1:0] addr;   // Cycle address
  logic [DATA_W-1:0] wdata;  // Write data
  logic              done;   // Cycle finished
  logic [DATA_W-1:0] rdata;  // Read data, valid with done

  // Sequencer side
  modport seq (output start, wr, addr, wdata, input done, rdata);
  // Engine side
  modport eng (input start, wr, addr, wdata, output done, rdata);
endinterface

// ### sps_pin_engine.sv
// Pin cycle engine: one timed write or read cycle on the flash pins.
// Assumes the flash data input is synchronous to sys_clk.
module sps_pin_engine
  import sps_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Sequencer handshake
  sps_bus_if.eng                 bus,
  // Flash pins
  output logic [ADDR_W-1:0]      fl_addr,
  output logic                   fl_ce_n,
  output logic                   fl_oe_n,
  output logic                   fl_we_n,
  output logic [DATA_W-1:0]      fl_dq_o,
  output logic                   fl_dq_oe,
  input  wire logic [DATA_W-1:0] fl_dq_i
);

  typedef enum logic [2:0] {E_IDLE, E_WLOW, E_WHIGH, E_RD, E_RHIGH} sps_eng_e;

  sps_eng_e          st_r, st_nxt;          // Phase
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;        // Phase timer
  logic [ADDR_W-1:0] addr_r, addr_nxt;      // Address pins
  logic              ce_r, ce_nxt;          // Chip enable, active low
  logic              oe_r, oe_nxt;          // Output enable, active low
  logic              we_r, we_nxt;          // Write strobe, active low
  logic [DATA_W-1:0] dout_r, dout_nxt;      // Data out
  logic              doe_r, doe_nxt;        // Data drive enable
  logic              done_r, done_nxt;      // Cycle done pulse
  logic [DATA_W-1:0] rdata_r, rdata_nxt;    // Captured read data

  // Next-state logic for the pin cycle
  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    addr_nxt  = addr_r;
    ce_nxt    = ce_r;
    oe_nxt    = oe_r;
    we_nxt    = we_r;
    dout_nxt  = dout_r;
    doe_nxt   = doe_r;
    done_nxt  = 1'b0;
    rdata_nxt = rdata_r;
    case (st_r)
      E_IDLE: begin
        if (bus.start) begin
          addr_nxt = bus.addr;
          ce_nxt   = 1'b0;
          if (bus.wr) begin
            // Write: output enable stays high while strobes are low
            oe_nxt   = 1'b1;
            we_nxt   = 1'b0;
            dout_nxt = bus.wdata;
            doe_nxt  = 1'b1;
            cnt_nxt  = CNT_W'(WP_CYC - 1);
            st_nxt   = E_WLOW;
          end else begin
            // Read: strobe both output and chip enable
            oe_nxt   = 1'b0;
            doe_nxt  = 1'b0;
            cnt_nxt  = CNT_W'(ACC_CYC - 1);
            st_nxt   = E_RD;
          end
        end
      end
      E_WLOW: begin
        // Hold the write pulse low
        if (cnt_r == '0) begin
          we_nxt  = 1'b1;
          ce_nxt  = 1'b1;
          cnt_nxt = CNT_W'(WPH_CYC - 1);
          st_nxt  = E_WHIGH;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      E_WHIGH: begin
        // Pulse high time, data still held
        if (cnt_r == '0) begin
          doe_nxt  = 1'b0;
          done_nxt = 1'b1;
          st_nxt   = E_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      E_RD: begin
        // Wait access time then capture
        if (cnt_r == '0) begin
          rdata_nxt = fl_dq_i;
          oe_nxt    = 1'b1;
          ce_nxt    = 1'b1;
          cnt_nxt   = CNT_W'(OEHP_CYC - 1);
          st_nxt    = E_RHIGH;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      E_RHIGH: begin
        // Enables high long enough before the next read
        if (cnt_r == '0) begin
          done_nxt = 1'b1;
          st_nxt   = E_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        st_nxt = E_IDLE;
      end
    endcase
  end

  // Registers of the pin cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r    <= E_IDLE;
      cnt_r   <= '0;
      addr_r  <= '0;
      ce_r    <= 1'b1;
      oe_r    <= 1'b1;
      we_r    <= 1'b1;
      dout_r  <= '0;
      doe_r   <= 1'b0;
      done_r  <= 1'b0;
      rdata_r <= '0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      addr_r  <= addr_nxt;
      ce_r    <= ce_nxt;
      oe_r    <= oe_nxt;
      we_r    <= we_nxt;
      dout_r  <= dout_nxt;
      doe_r   <= doe_nxt;
      done_r  <= done_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs straight from flops
  assign fl_addr   = addr_r;
  assign fl_ce_n   = ce_r;
  assign fl_oe_n   = oe_r;
  assign fl_we_n   = we_r;
  assign fl_dq_o   = dout_r;
  assign fl_dq_oe  = doe_r;
  assign bus.done  = done_r;
  assign bus.rdata = rdata_r;

endmodule

// ### sps_host.sv
// Host sequencer for sector programming, status polling and identification.
// Assumes the user holds cmd and word data steady until taken by ready.
module sps_host
  import sps_pkg::*;
#(
  parameter int WLC_CYC   = T_WLC_US * CLK_MHZ,          // Word load limit
  parameter int WLC_GUARD = WLC_CYC - 2 * (WP_CYC + WPH_CYC), // Abort margin
  parameter int WC_CYC    = T_WC_MS * CLK_MHZ * 1000      // Poll limit
)(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Command port
  input  wire logic              cmd_valid,
  input  wire logic [1:0]        cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  output logic                   cmd_ready,
  // Sector word feed
  input  wire logic              wd_valid,
  input  wire logic [DATA_W-1:0] wd_data,
  output logic                   wd_ready,
  // Results
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  output logic                   op_done,
  output logic                   op_err,
  output logic                   id_mode,
  // Flash pins
  output logic [ADDR_W-1:0]      fl_addr,
  output logic                   fl_ce_n,
  output logic                   fl_oe_n,
  output logic                   fl_we_n,
  output logic [DATA_W-1:0]      fl_dq_o,
  output logic                   fl_dq_oe,
  input  wire logic [DATA_W-1:0] fl_dq_i
);

  typedef enum logic [2:0] {S_IDLE, S_SEQ, S_LOAD, S_POLL, S_READ} sps_st_e;

  // Preamble address per step
  function automatic logic [ADDR_W-1:0] pre_addr(input logic [1:0] step);
    pre_addr = (step == 2'h1) ? UNL_ADDR_B : UNL_ADDR_A;
  endfunction

  // Preamble data per step and command
  function automatic logic [DATA_W-1:0] pre_data(input logic [1:0] step, input sps_op_e op);
    if (step == 2'h0) begin
      pre_data = UNL_DATA_A;
    end else if (step == 2'h1) begin
      pre_data = UNL_DATA_B;
    end else if (op == OP_PROGRAM) begin
      pre_data = CODE_PGM;
    end else if (op == OP_ID_ENTER) begin
      pre_data = CODE_ID_IN;
    end else begin
      pre_data = CODE_ID_OUT;
    end
  endfunction

  sps_bus_if bus ();

  sps_st_e           st_r, st_nxt;            // Sequencer state
  sps_op_e           op_r, op_nxt;            // Current command
  logic [ADDR_W-1:0] addr_r, addr_nxt;        // Command address
  logic [1:0]        step_r, step_nxt;        // Preamble step
  logic [IDX_W-1:0]  idx_r, idx_nxt;          // Word index in sector
  logic [31:0]       tmr_r, tmr_nxt;          // Load or poll timer
  logic              wait_r, wait_nxt;        // Pin cycle outstanding
  logic              start_r, start_nxt;      // Launch pulse
  logic              bwr_r, bwr_nxt;          // Launch is a write
  logic [ADDR_W-1:0] baddr_r, baddr_nxt;      // Launch address
  logic [DATA_W-1:0] bdata_r, bdata_nxt;      // Launch data
  logic [1:0]        prev_r, prev_nxt;        // Last toggle pair
  logic              havep_r, havep_nxt;      // A previous read exists
  logic              cmdr_r, cmdr_nxt;        // Command ready
  logic              wdr_r, wdr_nxt;          // Word ready
  logic              rdv_r, rdv_nxt;          // Read valid pulse
  logic [DATA_W-1:0] rdd_r, rdd_nxt;          // Read data
  logic              done_r, done_nxt;        // Done pulse
  logic              err_r, err_nxt;          // Error flag
  logic              idm_r, idm_nxt;          // Identification mode
  logic [1:0]        tog;                     // Toggle pair of this read

  assign tog = {bus.rdata[TOGGLE_HIGH_BIT], bus.rdata[TOGGLE_LOW_BIT]};

  // Sequencer next-state logic
  always_comb begin
    st_nxt    = st_r;
    op_nxt    = op_r;
    addr_nxt  = addr_r;
    step_nxt  = step_r;
    idx_nxt   = idx_r;
    tmr_nxt   = tmr_r;
    wait_nxt  = wait_r;
    start_nxt = 1'b0;
    bwr_nxt   = bwr_r;
    baddr_nxt = baddr_r;
    bdata_nxt = bdata_r;
    prev_nxt  = prev_r;
    havep_nxt = havep_r;
    rdv_nxt   = 1'b0;
    rdd_nxt   = rdd_r;
    done_nxt  = 1'b0;
    err_nxt   = err_r;
    idm_nxt   = idm_r;
    if (bus.done) begin
      wait_nxt = 1'b0;
    end
    case (st_r)
      S_IDLE: begin
        // New commands only while idle, after any program has finished or hit its poll limit
        if (cmd_valid && cmdr_r) begin
          op_nxt   = sps_op_e'(cmd_op);
          addr_nxt = cmd_addr;
          err_nxt  = 1'b0;
          step_nxt = 2'h0;
          if (sps_op_e'(cmd_op) == OP_READ) begin
            // Plain read, ids too in identification mode
            start_nxt = 1'b1;
            wait_nxt  = 1'b1;
            bwr_nxt   = 1'b0;
            baddr_nxt = cmd_addr;
            st_nxt    = S_READ;
          end else begin
            st_nxt = S_SEQ;
          end
        end
      end
      S_SEQ: begin
        // Unlock and command writes, always before any word load
        if (!wait_r) begin
          if (step_r <= LAST_STEP) begin
            start_nxt = 1'b1;
            wait_nxt  = 1'b1;
            bwr_nxt   = 1'b1;
            baddr_nxt = pre_addr(step_r);
            bdata_nxt = pre_data(step_r, op_r);
            step_nxt  = step_r + 1'b1;
          end else if (op_r == OP_PROGRAM) begin
            idx_nxt = '0;
            tmr_nxt = '0;
            st_nxt  = S_LOAD;
          end else begin
            // Entry or exit changes the read view
            idm_nxt  = (op_r == OP_ID_ENTER);
            done_nxt = 1'b1;
            st_nxt   = S_IDLE;
          end
        end
      end
      S_LOAD: begin
        // Full sector, every word under the same sector address
        tmr_nxt = tmr_r + 32'h1;
        if (wd_valid && wdr_r) begin
          start_nxt = 1'b1;
          wait_nxt  = 1'b1;
          bwr_nxt   = 1'b1;
          baddr_nxt = {addr_r[ADDR_W-1:SECT_LSB], idx_r};
          bdata_nxt = wd_data;
          idx_nxt   = idx_r + 1'b1;
          tmr_nxt   = '0;
          if (idx_r == LAST_IDX) begin
            havep_nxt = 1'b0;
            st_nxt    = S_POLL;
          end
        end else if (tmr_r >= 32'(WLC_GUARD)) begin
          // Feed too slow: partial sector, contents undefined
          err_nxt   = 1'b1;
          havep_nxt = 1'b0;
          tmr_nxt   = '0;
          st_nxt    = S_POLL;
        end
      end
      S_POLL: begin
        // Toggle polling at the fixed sector base address
        tmr_nxt = tmr_r + 32'h1;
        if (!wait_r && !start_r) begin
          start_nxt = 1'b1;
          wait_nxt  = 1'b1;
          bwr_nxt   = 1'b0;
          baddr_nxt = {addr_r[ADDR_W-1:SECT_LSB], {IDX_W{1'b0}}};
        end
        if (bus.done && !bwr_r) begin
          // Poll reads only, a late load write is no status; first read seeds
          prev_nxt  = tog;
          havep_nxt = 1'b1;
          if (havep_r && (tog == prev_r)) begin
            done_nxt = 1'b1;
            st_nxt   = S_IDLE;
          end
        end
        if (tmr_r >= 32'(WC_CYC) && st_nxt == S_POLL && !wait_nxt) begin
          err_nxt  = 1'b1;
          done_nxt = 1'b1;
          st_nxt   = S_IDLE;
        end
      end
      S_READ: begin
        // Return one read word
        if (bus.done) begin
          rdd_nxt  = bus.rdata;
          rdv_nxt  = 1'b1;
          done_nxt = 1'b1;
          st_nxt   = S_IDLE;
        end
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
    cmdr_nxt = (st_nxt == S_IDLE);
    wdr_nxt  = (st_nxt == S_LOAD) && !wait_nxt;
  end

  // Sequencer registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r    <= S_IDLE;
      op_r    <= OP_READ;
      addr_r  <= '0;
      step_r  <= 2'h0;
      idx_r   <= '0;
      tmr_r   <= '0;
      wait_r  <= 1'b0;
      start_r <= 1'b0;
      bwr_r   <= 1'b0;
      baddr_r <= '0;
      bdata_r <= '0;
      prev_r  <= 2'h0;
      havep_r <= 1'b0;
      cmdr_r  <= 1'b0;
      wdr_r   <= 1'b0;
      rdv_r   <= 1'b0;
      rdd_r   <= '0;
      done_r  <= 1'b0;
      err_r   <= 1'b0;
      idm_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      op_r    <= op_nxt;
      addr_r  <= addr_nxt;
      step_r  <= step_nxt;
      idx_r   <= idx_nxt;
      tmr_r   <= tmr_nxt;
      wait_r  <= wait_nxt;
      start_r <= start_nxt;
      bwr_r   <= bwr_nxt;
      baddr_r <= baddr_nxt;
      bdata_r <= bdata_nxt;
      prev_r  <= prev_nxt;
      havep_r <= havep_nxt;
      cmdr_r  <= cmdr_nxt;
      wdr_r   <= wdr_nxt;
      rdv_r   <= rdv_nxt;
      rdd_r   <= rdd_nxt;
      done_r  <= done_nxt;
      err_r   <= err_nxt;
      idm_r   <= idm_nxt;
    end
  end

  // Launch fields to the engine
  assign bus.start = start_r;
  assign bus.wr    = bwr_r;
  assign bus.addr  = baddr_r;
  assign bus.wdata = bdata_r;

  // User outputs from flops
  assign cmd_ready = cmdr_r;
  assign wd_ready  = wdr_r;
  assign rd_valid  = rdv_r;
  assign rd_data   = rdd_r;
  assign op_done   = done_r;
  assign op_err    = err_r;
  assign id_mode   = idm_r;

  // Pin cycle engine
  sps_pin_engine u_eng (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .bus      (bus),
    .fl_addr  (fl_addr),
    .fl_ce_n  (fl_ce_n),
    .fl_oe_n  (fl_oe_n),
    .fl_we_n  (fl_we_n),
    .fl_dq_o  (fl_dq_o),
    .fl_dq_oe (fl_dq_oe),
    .fl_dq_i  (fl_dq_i)
  );

endmodule

// ### sps_host_chk.sv
// Pin checker for the sector program host: write framing, unlock, loads, polling.
// Assumes it is bound into sps_host, one clock, sync active-high reset.
module sps_host_chk
  import sps_pkg::*;
#(
  parameter int WLC_CYC = 30000  // Device load phase limit
)(
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // Results
  input wire logic              cmd_ready,
  input wire logic              op_done,
  input wire logic              op_err,
  // Flash pins
  input wire logic [ADDR_W-1:0] fl_addr,
  input wire logic              fl_ce_n,
  input wire logic              fl_oe_n,
  input wire logic              fl_we_n,
  input wire logic [DATA_W-1:0] fl_dq_o,
  input wire logic [DATA_W-1:0] fl_dq_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic        we_q, oe_q;     // Strobes one edge back
  logic        armed, poll;    // Program code written, polling begun
  logic [7:0]  n_load;         // Words loaded
  logic [8:0]  sect;           // Sector of the first load
  logic [15:0] gap, poll_a;    // Cycles since a load, first poll address
  logic [15:0] cur, prv;       // Last two status words
  logic [1:0]  n_poll;         // Status reads, saturating
  wire logic   wr_go = we_q && !fl_we_n;  // Write strobe falls
  wire logic   rd_go = oe_q && !fl_oe_n;  // Read strobe falls
  // Follow a program operation as seen on the pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {we_q, oe_q} <= 2'b11;
      {armed, poll, n_load, n_poll, gap, sect, poll_a, cur, prv} <= '0;
    end else begin
      we_q <= fl_we_n;
      oe_q <= fl_oe_n;
      gap  <= (wr_go && armed) ? 16'h0000 : gap + {15'h0000, gap != 16'hffff};
      if (op_done) begin
        {armed, poll, n_load, n_poll} <= '0;
      end else begin
        if (wr_go && fl_addr == UNL_ADDR_A && fl_dq_o == CODE_PGM) armed <= 1'b1;
        if (wr_go && armed) n_load <= n_load + 8'h01;
        if (wr_go && armed && n_load == 8'h00) sect <= fl_addr[15:7];
        if (rd_go && armed) begin
          poll   <= 1'b1;
          prv    <= cur;
          n_poll <= n_poll + {1'b0, n_poll != 2'h3};
        end
        if (rd_go && armed && !poll) poll_a <= fl_addr;
        if (!rd_go && !fl_oe_n && armed) cur <= fl_dq_i;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A sector word load after the first one, and the first status read
  sequence s_load; wr_go && armed && n_load != 8'h00; endsequence
  sequence s_poll_first; rd_go && armed && !poll; endsequence
  oe_high_wr_a: assert property (!fl_we_n && !fl_ce_n |-> fl_oe_n)
    else $error("output enable low in a write");
  unlock_first_a: assert property (wr_go && fl_addr != UNL_ADDR_A && fl_addr != UNL_ADDR_B |-> armed)
    else $error("word load without unlock");
  cmd_byte_a: assert property (wr_go && !armed |-> fl_dq_o[15:8] == 8'h00 && !fl_addr[15])
    else $error("command outside low byte or address field");
  same_sector_a: assert property (s_load |-> fl_addr[15:7] == sect)
    else $error("sector changed during loads");
  load_gap_a: assert property (s_load |-> gap < WLC_CYC)
    else $error("word loads too far apart");
  full_sector_a: assert property (s_poll_first |-> n_load == 8'h80 || op_err)
    else $error("partial sector without error");
  poll_addr_a: assert property (rd_go && poll |-> fl_addr == poll_a)
    else $error("poll address moved");
  poll_done_a: assert property (op_done && armed && !op_err |-> n_poll >= 2'h2 && prv[14] == cur[14] && prv[6] == cur[6])
    else $error("done before toggle bits settled");
  cmd_back_a: assert property (op_done |-> ##[0:1] cmd_ready)
    else $error("command port not back after done");
endmodule

bind sps_host sps_host_chk #(.WLC_CYC(WLC_CYC)) u_chk (.*);

// ### sps_flash_model.sv
// Behavioural flash: command decoder, sector latches, toggle status, id words.
// Assumes tb_clk only as a timebase; the modelled part has no clock.
module sps_flash_model
  import sps_pkg::*;
#(
  parameter int          WLC_CYC  = 2000,     // Load phase limit in cycles
  parameter logic [15:0] MAKER_ID = 16'h00a5, // Arbitrary value
  parameter logic [15:0] PART_ID  = 16'h005a  // Arbitrary value
)(
  // Timebase and supply
  input  wire logic        tb_clk,
  input  wire logic        pwr_off,
  input  wire logic [15:0] prog_cyc,
  // Flash pins
  input  wire logic [15:0] fl_addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:65535];  // Array, erased to ones
  logic [15:0] lat [0:127];    // Sector latches
  logic [127:0] got;           // Latch filled flags
  logic [8:0]  sect;           // Latched sector
  logic [1:0]  step;           // Unlock progress
  logic        idm, loading, prog, tog, wr_q, rd_q;
  logic [15:0] hold, rdata;    // Last driven word, word to drive
  int          nload, tmr;
  wire logic   wr = !we_n && !ce_n;
  wire logic   rd = !oe_n && !ce_n && we_n;
  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
    {step, idm, loading, prog, tog, wr_q, rd_q, got, sect, hold} = '0;
    nload = 0;
    tmr = 0;
  end
  // Busy status, id words or array data
  always_comb begin
    if (loading || prog) rdata = 16'h4040 & {16{tog}};
    else if (idm && fl_addr[15:1] == 15'h0000) rdata = fl_addr[0] ? PART_ID : MAKER_ID;
    else rdata = mem[fl_addr];
  end
  // Released bus shows the inverse of the last word
  assign dq_out = rd ? rdata : ~hold;
  // Decode one completed write
  task automatic take_write(input logic [15:0] a, input logic [15:0] d);
    if (prog) return;
    if (loading) begin
      if (nload == 0) sect = a[15:7];
      if (a[15:7] == sect) begin
        lat[a[6:0]] = d;
        got[a[6:0]] = 1'b1;
        nload++;
        tmr = 0;
      end
      return;
    end
    case (step)
      2'h0: step = (a[14:0] == 15'h5555 && d[7:0] == 8'haa) ? 2'h1 : 2'h0;
      2'h1: step = (a[14:0] == 15'h2aaa && d[7:0] == 8'h55) ? 2'h2 : 2'h0;
      default: begin
        step = 2'h0;
        if (a[14:0] == 15'h5555 && d[7:0] == 8'ha0) loading = 1'b1;
        if (a[14:0] == 15'h5555 && d[7:0] == 8'h90) idm = 1'b1;
        if (a[14:0] == 15'h5555 && d[7:0] == 8'hf0) idm = 1'b0;
        tmr = 0;
      end
    endcase
  endtask
  // Strobe detection, load timer and program cycle
  always @(posedge tb_clk) begin
    if (rd) hold = rdata;
    if (rd && !rd_q && (loading || prog)) tog = ~tog;
    if (wr_q && !wr) take_write(fl_addr, dq_in);
    tmr++;
    if (loading && (nload == 128 || tmr >= WLC_CYC)) begin
      loading = 1'b0;
      prog = 1'b1;
      tmr = 0;
    end else if (prog && tmr >= int'(prog_cyc)) begin
      for (int i = 0; i < 128; i++) mem[{sect, i[6:0]}] = got[i] ? lat[i] : 16'hxxxx;
      prog = 1'b0;
      got = '0;
      nload = 0;
    end
    if (pwr_off) {idm, step} = '0;
    wr_q = wr;
    rd_q = rd;
  end
endmodule

// ### sps_host_tb.sv
// Self-checking bench: sps_host against the behavioural flash.
// Assumes the package, design, checker and flash model are compiled first.
module sps_host_tb;
  import sps_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] MAKER = 16'h00a5;  // Arbitrary value
  localparam logic [15:0] PART  = 16'h005a;  // Arbitrary value
  logic        sys_clk, rst, cmd_valid, wd_valid, pwr_off, res_err;
  logic [1:0]  cmd_op;
  logic [15:0] cmd_addr, wd_data, prog_cyc, rd_data, fl_addr, fl_dq_o, mdl_dq, res_data;
  logic        cmd_ready, wd_ready, rd_valid, op_done, op_err, id_mode;
  logic        fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe;
  int          n_errors, total_checks;
  wire logic [15:0] fl_dq_i = fl_dq_oe ? fl_dq_o : mdl_dq;  // Shared data bus
  sps_host #(.WLC_CYC(2000), .WLC_GUARD(1500), .WC_CYC(3000)) dut (.*);
  sps_flash_model #(.WLC_CYC(2000), .MAKER_ID(MAKER), .PART_ID(PART)) u_flash (
    .tb_clk(sys_clk), .pwr_off(pwr_off), .prog_cyc(prog_cyc), .fl_addr(fl_addr), .ce_n(fl_ce_n),
    .oe_n(fl_oe_n), .we_n(fl_we_n), .dq_in(fl_dq_o), .dq_out(mdl_dq));
  // Clock, 5 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic fault(input string msg);
    n_errors++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) fault($sformatf("word %h, expected %h", got, exp));
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) fault($sformatf("flag %b, expected %b", got, exp));
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Offer a command, hold until taken
  task automatic send_cmd(input logic [1:0] op, input logic [15:0] a);
    int w;
    {cmd_op, cmd_addr, cmd_valid, w} = {op, a, 1'b1, 32'd0};
    do begin @(posedge sys_clk); w++; end while (cmd_ready !== 1'b1 && w < 100);
    #1;
    cmd_valid = 1'b0;
    if (w >= 100) fault("command not taken");
  endtask
  // Feed n sector words, value base plus index
  task automatic feed(input int n, input logic [15:0] base);
    int w;
    for (int i = 0; i < n; i++) begin
      {wd_data, wd_valid, w} = {base + i[15:0], 1'b1, 32'd0};
      do begin @(posedge sys_clk); w++; end while (wd_ready !== 1'b1 && w < 3000);
      #1;
      if (w >= 3000) fault("word not taken");
    end
    wd_valid = 1'b0;
  endtask
  // Wait for op_done, keep results
  task automatic wait_done(input int lim);
    int w;
    w = 0;
    do begin tick(1); w++; end while (op_done !== 1'b1 && w < lim);
    res_err = op_err;
    res_data = rd_data;
    if (w >= lim) fault("no completion");
  endtask
  task automatic do_read(input logic [15:0] a, input logic [15:0] exp);
    send_cmd(OP_READ, a);
    wait_done(200);
    chk_bit(rd_valid, 1'b1);
    chk_word(res_data, exp);
  endtask
  // Idle pins in reset, ready after release
  task automatic t_reset();
    chk_bit(fl_we_n & fl_ce_n & fl_oe_n & !fl_dq_oe, 1'b1);
    rst = 1'b0;
    tick(2);
    chk_bit(cmd_ready, 1'b1);
  endtask
  // Full sector, read back ends and middle
  task automatic t_full();
    send_cmd(OP_PROGRAM, 16'h0300);
    feed(128, 16'h3c00);
    wait_done(20000);
    chk_bit(res_err, 1'b0);
    do_read(16'h0300, 16'h3c00);
    do_read(16'h037f, 16'h3c7f);
    do_read(16'h0340, 16'h3c40);
  endtask
  // Five words only: load timeout, partial sector
  task automatic t_partial();
    send_cmd(OP_PROGRAM, 16'h0480);
    feed(5, 16'h7100);
    wait_done(20000);
    chk_bit(res_err, 1'b1);
    do_read(16'h0484, 16'h7104);
  endtask
  // Slow program: host stops polling, error
  task automatic t_slow();
    prog_cyc = 16'd6000;
    send_cmd(OP_PROGRAM, 16'h0500);
    feed(128, 16'h9000);
    wait_done(20000);
    chk_bit(res_err, 1'b1);
    tick(5000);
    prog_cyc = 16'd1000;
    do_read(16'h0505, 16'h9005);
  endtask
  // Id words, exit, id loss at power down
  task automatic t_id();
    send_cmd(OP_ID_ENTER, 16'h0000);
    wait_done(1000);
    chk_bit(id_mode, 1'b1);
    do_read(16'h0000, MAKER);
    do_read(16'h0001, PART);
    do_read(16'h0301, 16'h3c01);
    send_cmd(OP_ID_EXIT, 16'h0000);
    wait_done(1000);
    chk_bit(id_mode, 1'b0);
    do_read(16'h0000, 16'hffff);
    send_cmd(OP_ID_ENTER, 16'h0000);
    wait_done(1000);
    pwr_off = 1'b1;
    rst = 1'b1;
    tick(2);
    {pwr_off, rst} = 2'b00;
    tick(2);
    do_read(16'h0000, 16'hffff);
  endtask
  // Main sequence
  initial begin
    {rst, cmd_valid, wd_valid, pwr_off, cmd_op, cmd_addr, wd_data} = {1'b1, 3'b000, 2'h0, 32'h0};
    prog_cyc = 16'd1000;
    n_errors = 0;
    total_checks = 0;
    tick(20);
    t_reset();
    t_full();
    t_partial();
    t_slow();
    t_id();
    end_of_test();
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_errors++;
    end_of_test();
  end
endmodule
